// File: src/csf_alu_flags.sv
`timescale 1ns/1ns
module csf_alu_flags (
  input wire csf_pkg::csf_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] result_in,
  output logic zero_out,
  output logic half_carry_out,
  output logic carry_out,
  output logic z_upd_out,
  output logic dc_upd_out,
  output logic c_upd_out
);
  wire [4:0] lo_add;
  wire [4:0] lo_sub;
  wire [8:0] full_add;
  wire [8:0] full_sub;
  assign lo_add = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
  // Subtract is file minus W; bit 4 set means a borrow
  assign lo_sub = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]};
  assign full_add = {1'b0, a_in} + {1'b0, b_in};
  assign full_sub = {1'b0, a_in} - {1'b0, b_in};
  assign zero_out = (result_in == 8'h00);
  assign half_carry_out = (op_in == csf_pkg::CSF_OP_SUB) ? ~lo_sub[4] : lo_add[4];
  assign carry_out = (op_in == csf_pkg::CSF_OP_ADD) ? full_add[8] :
                     (op_in == csf_pkg::CSF_OP_SUB) ? ~full_sub[8] :
                     (op_in == csf_pkg::CSF_OP_RRF) ? a_in[0] : a_in[7];
  assign z_upd_out = (op_in == csf_pkg::CSF_OP_ADD) || (op_in == csf_pkg::CSF_OP_SUB) ||
                     (op_in == csf_pkg::CSF_OP_ZONLY) || (op_in == csf_pkg::CSF_OP_CLEAR_FILE_OP);
  assign dc_upd_out = (op_in == csf_pkg::CSF_OP_ADD) || (op_in == csf_pkg::CSF_OP_SUB);
  assign c_upd_out = dc_upd_out || (op_in == csf_pkg::CSF_OP_RRF) ||
                     (op_in == csf_pkg::CSF_OP_RLF);
endmodule : csf_alu_flags

// File: src/csf_pkg.sv
// Function
// - Status register accepts any instruction write; plain bits take the written value.
// - Flag-updating instructions targeting status: data write to zero, half carry, carry disabled.
// - Timeout and powerdown flags ignore instruction writes entirely.
// - clear_file_op on status clears top three bits and sets zero flag.
// - Bit 5 page_preselect: 1 selects page 200h-3FFh, 0 selects 000h-1FFh.
// - Timeout flag set at power-up, clear_watchdog_op and sleep.
// - Timeout flag cleared when the watchdog timer expires.
// - add_w_file_op: half carry is carry out of low nibble.
// - sub_w_file_op: half carry is inverted borrow from low nibble.
// - Carry: add carry out, subtract inverted borrow, rotates load shifted-out bit.
// - page_preselect supplies program counter bit 9 on jumps.
package csf_pkg;
  localparam logic [4:0] CSF_STATUS_ADDR = 5'h03;
  localparam int CSF_BIT_C = 0;
  localparam int CSF_BIT_DC = 1;
  localparam int CSF_BIT_Z = 2;
  localparam int CSF_BIT_PD = 3;
  localparam int CSF_BIT_TO = 4;
  localparam int CSF_BIT_PA = 5;
  localparam int CSF_BIT_WAKE = 7;
  localparam int CSF_PC_PAGE_BIT = 9;
  localparam logic [7:0] CSF_POR_VALUE = 8'h18;
  localparam logic [7:0] CSF_IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] CSF_EVT_ADDR = 8'h10;
  localparam logic [7:0] CSF_MASK_ADDR = 8'h11;
  localparam logic [7:0] CSF_STAT_ADDR = 8'h12;
  localparam int CSF_EVT_WDT = 0;
  localparam int CSF_EVT_SLEEP = 1;
  localparam int CSF_EVT_WAKE = 2;
  typedef enum logic [2:0] {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_RRF,
    CSF_OP_RLF,
    CSF_OP_ZONLY,
    CSF_OP_CLEAR_FILE_OP
  } csf_op_t;
endpackage : csf_pkg

// File: src/csf_status_reg.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module csf_status_reg (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic exec_in,
  input wire csf_pkg::csf_op_t op_in,
  input wire logic [4:0] dest_addr_in,
  input wire logic dest_we_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] result_in,
  input wire logic clear_watchdog_op_in,
  input wire logic sleep_in,
  input wire logic wdt_expire_in,
  input wire logic wake_reset_in,
  input wire logic other_reset_in,
  input wire logic goto_in,
  input wire logic [8:0] goto_target_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] status_out,
  output logic [9:0] pc_jump_out,
  output logic page_preselect_out,
  output logic irq_out
);
  logic carry_r;
  logic half_carry_flag_r;
  logic zero_r;
  logic powerdown_flag_r;
  logic timeout_flag_r;
  logic page_preselect_r;
  logic pin_wake_reset_flag_r;
  logic [2:0] evt_r;
  logic [2:0] evt_nxt;
  logic [2:0] mask_r;
  logic [7:0] reg_rdata_r;
  logic [7:0] rdata_nxt;
  logic [9:0] pc_jump_r;
  wire alu_zero;
  wire alu_dc;
  wire alu_c;
  wire z_upd;
  wire dc_upd;
  wire c_upd;
  wire hit;
  wire wr_hit;
  wire is_clear_file_op;
  wire any_upd;
  wire [7:0] wr_val;
  wire [2:0] evt_set;
  wire [2:0] evt_clr;

  csf_alu_flags u_flags (
    .op_in(op_in),
    .a_in(a_in),
    .b_in(b_in),
    .result_in(result_in),
    .zero_out(alu_zero),
    .half_carry_out(alu_dc),
    .carry_out(alu_c),
    .z_upd_out(z_upd),
    .dc_upd_out(dc_upd),
    .c_upd_out(c_upd)
  );

  assign hit = (dest_addr_in == csf_pkg::CSF_STATUS_ADDR);
  assign wr_hit = exec_in && dest_we_in && hit;
  assign is_clear_file_op = (op_in == csf_pkg::CSF_OP_CLEAR_FILE_OP);
  // Any flag update locks all three arithmetic bits against the data write
  assign any_upd = z_upd || dc_upd || c_upd;
  // A clear writes zero; zero flag is then forced to one
  assign wr_val = is_clear_file_op ? 8'h00 : result_in;

  // Arithmetic flags: ALU wins over a data write to the same bits
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      carry_r <= 1'b0;
      half_carry_flag_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else if (exec_in)
    begin
      if (c_upd)
        carry_r <= alu_c;
      else if (wr_hit && !any_upd)
        carry_r <= wr_val[csf_pkg::CSF_BIT_C];
      if (dc_upd)
        half_carry_flag_r <= alu_dc;
      else if (wr_hit && !any_upd)
        half_carry_flag_r <= wr_val[csf_pkg::CSF_BIT_DC];
      if (z_upd)
        zero_r <= is_clear_file_op ? 1'b1 : alu_zero;
      else if (wr_hit && !any_upd)
        zero_r <= wr_val[csf_pkg::CSF_BIT_Z];
    end
  end

  // Timeout and powerdown: hardware only; reset state is the power-up value
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b1;
    end
    else
    begin
      if (wdt_expire_in)
        timeout_flag_r <= 1'b0;
      else if (exec_in && (clear_watchdog_op_in || sleep_in))
        timeout_flag_r <= 1'b1;
      if (exec_in && sleep_in)
        powerdown_flag_r <= 1'b0;
      else if (exec_in && clear_watchdog_op_in)
        powerdown_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      page_preselect_r <= 1'b0;
    else if (wr_hit)
      page_preselect_r <= wr_val[csf_pkg::CSF_BIT_PA];
  end

  // Wake flag follows the cause of the latest non-power-up reset, or the bit written by the latest status write
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pin_wake_reset_flag_r <= 1'b0;
    else if (wake_reset_in)
      pin_wake_reset_flag_r <= 1'b1;
    else if (other_reset_in)
      pin_wake_reset_flag_r <= 1'b0;
    else if (wr_hit)
      pin_wake_reset_flag_r <= wr_val[csf_pkg::CSF_BIT_WAKE];
  end

  // Bit 6 is a constant zero, so writes to it vanish
  assign status_out = {pin_wake_reset_flag_r, 1'b0, page_preselect_r, timeout_flag_r,
                       powerdown_flag_r, zero_r, half_carry_flag_r, carry_r};
  assign page_preselect_out = page_preselect_r;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pc_jump_r <= 10'h000;
    else if (goto_in)
      pc_jump_r <= {page_preselect_r, goto_target_in};
  end
  assign pc_jump_out = pc_jump_r;

  // Event bits: set wins over a write-one clear in the same cycle
  assign evt_set = {wake_reset_in, exec_in && sleep_in, wdt_expire_in};
  assign evt_clr = (reg_wr_in && reg_addr_in == csf_pkg::CSF_EVT_ADDR) ? reg_wdata_in[2:0] :
                   3'h0;
  assign evt_nxt = evt_set | (evt_r & ~evt_clr);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      evt_r <= 3'h0;
      mask_r <= csf_pkg::CSF_IRQ_MASK_RST[2:0];
    end
    else
    begin
      evt_r <= evt_nxt;
      if (reg_wr_in && reg_addr_in == csf_pkg::CSF_MASK_ADDR)
        mask_r <= reg_wdata_in[2:0];
    end
  end
  assign irq_out = |(evt_r & mask_r);

  assign rdata_nxt = (reg_addr_in == csf_pkg::CSF_EVT_ADDR) ? {5'h00, evt_r} :
                     (reg_addr_in == csf_pkg::CSF_MASK_ADDR) ? {5'h00, mask_r} :
                     (reg_addr_in == csf_pkg::CSF_STAT_ADDR) ? status_out : 8'h00;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_r <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= 8'h00;
  end
  assign reg_rdata_out = reg_rdata_r;

  property p_sleep_flags;
    @(posedge clk_in) disable iff (!rst_b_in)
    (exec_in && sleep_in && !wdt_expire_in) |=> (timeout_flag_r && !powerdown_flag_r);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

  property p_wdt_clear;
    @(posedge clk_in) disable iff (!rst_b_in)
    wdt_expire_in |=> !timeout_flag_r;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("timeout not cleared");

  property p_clear_file_op;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && is_clear_file_op && !wake_reset_in) |=> (status_out[7:5] == 3'h0 && zero_r);
  endproperty
  a_clear_file_op: assert property (p_clear_file_op) else $error("clear of status wrong");

  property p_protect;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && !wdt_expire_in && !clear_watchdog_op_in && !sleep_in) |=>
      (timeout_flag_r == $past(timeout_flag_r) && powerdown_flag_r == $past(powerdown_flag_r));
  endproperty
  a_protect: assert property (p_protect) else $error("protected bit written");

  property p_add_carry;
    @(posedge clk_in) disable iff (!rst_b_in)
    (exec_in && op_in == csf_pkg::CSF_OP_ADD) |=>
      (carry_r == ((9'($past(a_in)) + 9'($past(b_in))) > 9'h0FF));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_add_dc;
    @(posedge clk_in) disable iff (!rst_b_in)
    (exec_in && op_in == csf_pkg::CSF_OP_ADD) |=>
      (half_carry_flag_r == (({1'b0, $past(a_in[3:0])} + {1'b0, $past(b_in[3:0])}) > 5'h0F));
  endproperty
  a_add_dc: assert property (p_add_dc) else $error("add half carry wrong");

  property p_sub_dc;
    @(posedge clk_in) disable iff (!rst_b_in)
    (exec_in && op_in == csf_pkg::CSF_OP_SUB) |=>
      (half_carry_flag_r == ($past(a_in[3:0]) >= $past(b_in[3:0])));
  endproperty
  a_sub_dc: assert property (p_sub_dc) else $error("sub half carry wrong");

  property p_page;
    @(posedge clk_in) disable iff (!rst_b_in)
    goto_in |=> (pc_jump_out[9] == $past(page_preselect_out) &&
                 pc_jump_out[8:0] == $past(goto_target_in));
  endproperty
  a_page: assert property (p_page) else $error("page bit not on pc");

  property p_bit6;
    @(posedge clk_in) disable iff (!rst_b_in)
    !status_out[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 nonzero");

  property p_wake;
    @(posedge clk_in) disable iff (!rst_b_in)
    wake_reset_in |=> pin_wake_reset_flag_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set");

  property p_clear_file_op_keep;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && is_clear_file_op) |=>
      (carry_r == $past(carry_r) && half_carry_flag_r == $past(half_carry_flag_r));
  endproperty
  a_clear_file_op_keep: assert property (p_clear_file_op_keep) else $error("clear altered carry bits");

  property p_zonly_lock;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_hit && op_in == csf_pkg::CSF_OP_ZONLY) |=>
      (carry_r == $past(carry_r) && half_carry_flag_r == $past(half_carry_flag_r));
  endproperty
  a_zonly_lock: assert property (p_zonly_lock) else $error("flag write not locked");
endmodule : csf_status_reg

// File: verif/cpu_status_flag_register_tb_top.sv
`timescale 1ns/1ns
module cpu_status_flag_register_tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic exec = 1'b0, dwe = 1'b0, clear_watchdog_op = 1'b0, slp = 1'b0, rw = 1'b0, rr = 1'b0;
  logic [3:0] ev = 4'h0;
  csf_pkg::csf_op_t op = csf_pkg::CSF_OP_NONE;
  logic [4:0] dest = 5'h00;
  logic [7:0] a = 8'h00, b = 8'h00, ra = 8'h00, rwd = 8'h00, res, rdata, st;
  logic [8:0] gtgt = 9'h000;
  logic [9:0] pcj;
  logic pg, irq;
  int n_errors = 0, checks = 0, cyc = 0;
  // Op, file operand, W operand, expected {zero, half carry, carry}; order matters
  localparam logic [21:0] ROWS [10] = '{
    {3'h1, 8'h0F, 8'h01, 3'h2}, {3'h1, 8'hF0, 8'h10, 3'h5}, {3'h2, 8'h10, 8'h01, 3'h1},
    {3'h2, 8'h01, 8'h02, 3'h0}, {3'h3, 8'h01, 8'h00, 3'h1}, {3'h4, 8'h01, 8'h00, 3'h0},
    {3'h2, 8'h05, 8'h05, 3'h7}, {3'h3, 8'h02, 8'h00, 3'h6}, {3'h5, 8'h05, 8'h0F, 3'h2},
    {3'h5, 8'h0F, 8'hF0, 3'h6}};
  csf_cpu_model i_csf_cpu_model (.op_in(op), .a_in(a), .b_in(b), .carry_in(st[0]),
    .result_out(res));
  csf_status_reg i_csf_status_reg (.clk_in(clk_in), .rst_b_in(rst_b_in), .exec_in(exec),
    .op_in(op), .dest_addr_in(dest), .dest_we_in(dwe), .a_in(a), .b_in(b), .result_in(res),
    .clear_watchdog_op_in(clear_watchdog_op), .sleep_in(slp), .wdt_expire_in(ev[0]), .wake_reset_in(ev[1]),
    .other_reset_in(ev[2]), .goto_in(ev[3]), .goto_target_in(gtgt), .reg_addr_in(ra),
    .reg_wdata_in(rwd), .reg_wr_in(rw), .reg_rd_in(rr), .reg_rdata_out(rdata),
    .status_out(st), .pc_jump_out(pcj), .page_preselect_out(pg), .irq_out(irq));
  always #25 clk_in = ~clk_in;
  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Ceiling well above the roughly 66 cycles the sequence needs
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task exe(input csf_pkg::csf_op_t o, input logic [7:0] x, input logic [7:0] y,
    input logic [4:0] d, input logic w, input logic [1:0] sp);
    @(posedge clk_in);
    exec <= 1'b1;
    op <= o;
    a <= x;
    b <= y;
    dest <= d;
    dwe <= w;
    {slp, clear_watchdog_op} <= sp;
    @(posedge clk_in);
    exec <= 1'b0;
    dwe <= 1'b0;
    {slp, clear_watchdog_op} <= 2'b00;
    #1;
  endtask : exe
  task pulse(input logic [3:0] m);
    @(posedge clk_in);
    ev <= m;
    gtgt <= 9'h1AB;
    @(posedge clk_in);
    ev <= 4'h0;
    #1;
  endtask : pulse
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    rw <= 1'b1;
    ra <= ad;
    rwd <= d;
    @(posedge clk_in);
    rw <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk_in);
    rr <= 1'b1;
    ra <= ad;
    @(posedge clk_in);
    rr <= 1'b0;
    #1;
    chk({2'b00, rdata}, {2'b00, e});
  endtask : rd
  initial
  begin
    repeat (10) @(posedge clk_in);
    chk({2'b00, st}, 10'h018);
    chk(pcj, 10'h000);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      exe(csf_pkg::csf_op_t'(ROWS[i][21:19]), ROWS[i][18:11], ROWS[i][10:3], 5'h07, 1'b1, 2'b00);
      chk({7'h00, st[2:0]}, {7'h00, ROWS[i][2:0]});
    end
    exe(csf_pkg::CSF_OP_NONE, 8'hFF, 8'h00, 5'h03, 1'b1, 2'b00);
    chk({2'b00, st}, 10'h0BF);
    chk({9'h000, pg}, 10'h001);
    pulse(4'h8);
    chk(pcj, 10'h3AB);
    exe(csf_pkg::CSF_OP_NONE, 8'hE3, 8'h00, 5'h03, 1'b1, 2'b00);
    chk({2'b00, st}, 10'h0BB);
    exe(csf_pkg::CSF_OP_CLEAR_FILE_OP, 8'h55, 8'h00, 5'h03, 1'b1, 2'b00);
    chk({2'b00, st}, 10'h01F);
    exe(csf_pkg::CSF_OP_ADD, 8'hF0, 8'h10, 5'h03, 1'b1, 2'b00);
    chk({2'b00, st}, 10'h01D);
    rd(8'h12, 8'h1D);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h1D);
    rd(8'h20, 8'h00);
    pulse(4'h1);
    chk({2'b00, st}, 10'h00D);
    exe(csf_pkg::CSF_OP_NONE, 8'h00, 8'h00, 5'h07, 1'b0, 2'b10);
    chk({2'b00, st}, 10'h015);
    exe(csf_pkg::CSF_OP_NONE, 8'h00, 8'h00, 5'h07, 1'b0, 2'b01);
    chk({2'b00, st}, 10'h01D);
    pulse(4'h2);
    chk({9'h000, st[7]}, 10'h001);
    pulse(4'h4);
    chk({9'h000, st[7]}, 10'h000);
    rd(8'h10, 8'h07);
    chk({9'h000, irq}, 10'h000);
    wr(8'h11, 8'h01);
    chk({9'h000, irq}, 10'h001);
    wr(8'h10, 8'h07);
    chk({9'h000, irq}, 10'h000);
    rd(8'h10, 8'h00);
    finish_test();
  end
endmodule : cpu_status_flag_register_tb_top

// File: verif/csf_cpu_model.sv
`timescale 1ns/1ns
module csf_cpu_model (
  input wire csf_pkg::csf_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  output logic [7:0] result_out
);
  // Status bits are altered by moves and bit ops through the NONE class
  // Page bit is written only as a page select, never as spare storage
  always_comb
  begin
    case (op_in)
      csf_pkg::CSF_OP_ADD: result_out = a_in + b_in;
      csf_pkg::CSF_OP_SUB: result_out = a_in - b_in;
      csf_pkg::CSF_OP_RRF: result_out = {carry_in, a_in[7:1]};
      csf_pkg::CSF_OP_RLF: result_out = {a_in[6:0], carry_in};
      csf_pkg::CSF_OP_ZONLY: result_out = a_in & b_in;
      csf_pkg::CSF_OP_CLEAR_FILE_OP: result_out = 8'h00;
      default: result_out = a_in;
    endcase
  end
endmodule : csf_cpu_model
